// *** logic/bscan_ctrl.sv ***
// boundary-scan test access port with instruction decode, pin control and config hooks
// Notes on behaviour
// [R01] scan pin effects only outside configuration
// [R02] sample/preload captures pins, preloads pattern
// [R03] extest drives outputs from boundary register
// [R04] all-ones code selects one-bit bypass
// [R05] usercode selects 32-bit user register
// [R06] idcode selects identification register
// [R07] highz uses bypass, floats every pin
// [R08] clamp uses bypass, holds boundary levels
// [R09] pulse code triggers internal reconfiguration
// [R10] io-standard code accepted at any time
// [R11] io-standard code halts running configuration
// [R12] io-standard code holds status low
// [R13] io standards updatable through chain anytime
// [R14] pins undriven until powered and configured; extest and clamp drive them once powered, configured or not
// [R15] instruction register is ten bits
// [R16] keepers override scan high-impedance
// [R17] id: version, part, maker, lsb one
// [R18] standard sixteen-state tap, tdo on falling
// [R19] unknown codes select bypass, normal pins
`timescale 1ns/1ps
`include "bscan_regs.svh"
module bscan_ctrl
  import bscan_pkg::*;
#(
  parameter int          N_PINS    = 8,
  parameter int          IOSTD_W   = 2,
  parameter logic [3:0]  VERSION   = 4'h0,
  parameter logic [15:0] PART_NUM  = 16'h1234,  // arbitrary value
  parameter logic [10:0] MAKER_ID  = 11'h155,   // arbitrary value
  parameter logic [31:0] USER_CODE = 32'hFFFFFFFF
) (
  // master clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       rst_in,
  // test access port
  input  wire logic                       tck_in,
  input  wire logic                       tms_in,
  input  wire logic                       tdi_in,
  output logic                            tdo_out,
  output logic                            tdo_oe_n_out,
  // configuration
  input  wire logic                       power_good_in,
  input  wire logic                       configured_in,
  input  wire logic                       config_busy_in,
  input  wire logic                       config_status_n_in,
  output logic                            config_status_n_out,
  output logic                            config_status_n_oe_n_out,
  output logic                            reconfig_req_out,
  output logic                            config_halt_out,
  output logic                            status_low_out,
  // user pins
  input  wire logic [N_PINS-1:0]          core_out_in,
  input  wire logic [N_PINS-1:0]          core_oe_n_in,
  input  wire logic [N_PINS-1:0]          keep_en_in,
  input  wire logic [N_PINS-1:0]          pad_in,
  output logic      [N_PINS-1:0]          pad_out,
  output logic      [N_PINS-1:0]          pad_oe_n_out,
  output logic      [N_PINS-1:0]          pad_keep_out,
  output logic      [N_PINS*IOSTD_W-1:0]  io_std_out
);
  localparam int BSR_W = N_PINS * `CELLS_PER_PIN;
  localparam int STD_W = N_PINS * IOSTD_W;
  localparam int LVL_W = 2 + BSR_W + STD_W;
  localparam logic [31:0] ID_VALUE = {VERSION, PART_NUM, MAKER_ID, 1'b1};  // see [R17]

  if (N_PINS < 1 || IOSTD_W < 1 || STD_W < 2) begin : g_bad_param
    $error("bscan_ctrl: pins and io-standard width positive, at least two io-standard cells");
  end

  function automatic dr_sel_t sel_of(input logic [`IR_LEN-1:0] op);
    unique case (op)
      `OP_IDCODE:                   sel_of = SEL_ID;        // see [R06]
      `OP_USERCODE:                 sel_of = SEL_USER;      // see [R05]
      `OP_EXTEST, `OP_SAMPLE:       sel_of = SEL_BOUNDARY;  // see [R02] see [R03]
      `OP_CONFIG_IO:                sel_of = SEL_IOSTD;     // see [R13]
      default:                      sel_of = SEL_BYPASS;    // see [R04] see [R19]
    endcase
  endfunction

  function automatic pin_mode_t mode_of(input logic [`IR_LEN-1:0] op);
    unique case (op)
      `OP_EXTEST, `OP_CLAMP: mode_of = PM_DRIVE;   // see [R03] see [R08]
      `OP_HIGHZ:             mode_of = PM_HIZ;     // see [R07]
      default:               mode_of = PM_NORMAL;  // see [R19]
    endcase
  endfunction

  // ---------------- test clock domain ----------------
  logic                   trst_s1;
  logic                   trst_s2;
  logic [3*N_PINS-1:0]    in_s1;
  logic [3*N_PINS-1:0]    in_s2;
  tap_state_t             state;
  tap_state_t             next_state;
  logic [`IR_LEN-1:0]     ir_shift;
  logic [`IR_LEN-1:0]     next_ir_shift;
  logic [`IR_LEN-1:0]     ir;
  logic [`IR_LEN-1:0]     next_ir;
  logic [`ID_LEN-1:0]     dr_shift;
  logic [`ID_LEN-1:0]     next_dr_shift;
  logic                   bypass_q;
  logic                   next_bypass;
  logic                   pulse_tgl;
  logic                   next_pulse_tgl;
  logic                   cfgio_tgl;
  logic                   next_cfgio_tgl;
  pin_mode_t              mode;
  pin_mode_t              next_mode;
  logic                   tdo_q;
  logic                   next_tdo;
  logic                   tdo_oe_n_q;
  logic                   next_tdo_oe_n;
  dr_sel_t                sel;
  logic [BSR_W-1:0]       bsr_cap;
  logic [BSR_W-1:0]       bsr_upd;
  logic [STD_W-1:0]       std_upd;
  logic                   bsr_so;
  logic                   std_so;
  logic                   cap_dr;
  logic                   sh_dr;
  logic                   up_dr;

  assign sel    = sel_of(ir);
  assign cap_dr = (state == TAP_CAP_DR);
  assign sh_dr  = (state == TAP_SHIFT_DR);
  assign up_dr  = (state == TAP_UPD_DR);

  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      bsr_cap[i*`CELLS_PER_PIN + `CELL_INPUT]  = in_s2[i];
      bsr_cap[i*`CELLS_PER_PIN + `CELL_DATA]   = in_s2[N_PINS + i];
      bsr_cap[i*`CELLS_PER_PIN + `CELL_ENABLE] = ~in_s2[2*N_PINS + i];
    end
  end

  bscan_chain #(.W(BSR_W)) u_boundary (
    .clk_in          (tck_in),
    .rst_in          (trst_s2),
    .capture_in      (cap_dr && sel == SEL_BOUNDARY),  // see [R02]
    .shift_in        (sh_dr && sel == SEL_BOUNDARY),
    .update_in       (up_dr && sel == SEL_BOUNDARY),   // see [R02]
    .serial_in       (tdi_in),
    .capture_data_in (bsr_cap),
    .serial_out      (bsr_so),
    .update_data_out (bsr_upd)
  );

  // io standards can be reloaded whatever the configuration is doing
  bscan_chain #(.W(STD_W)) u_iostd (
    .clk_in          (tck_in),
    .rst_in          (trst_s2),
    .capture_in      (cap_dr && sel == SEL_IOSTD),
    .shift_in        (sh_dr && sel == SEL_IOSTD),     // see [R10] see [R13]
    .update_in       (up_dr && sel == SEL_IOSTD),     // see [R13]
    .serial_in       (tdi_in),
    .capture_data_in (std_upd),
    .serial_out      (std_so),
    .update_data_out (std_upd)
  );

  always_comb begin
    next_state = state;
    unique case (state)  // see [R18]
      TAP_RESET:    next_state = tms_in ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     next_state = tms_in ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   next_state = tms_in ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   next_state = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_state = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_state = tms_in ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_state = tms_in ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_state = tms_in ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   next_state = tms_in ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   next_state = tms_in ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   next_state = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_state = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_state = tms_in ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_state = tms_in ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_state = tms_in ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   next_state = tms_in ? TAP_SEL_DR   : TAP_IDLE;
    endcase
  end

  always_comb begin
    next_ir_shift  = ir_shift;
    next_ir        = ir;
    next_dr_shift  = dr_shift;
    next_bypass    = bypass_q;
    next_pulse_tgl = pulse_tgl;
    next_cfgio_tgl = cfgio_tgl;
    next_mode      = mode;
    if (state == TAP_RESET) begin
      next_ir   = `IR_RESET_VAL;
      next_mode = PM_NORMAL;
    end
    if (state == TAP_CAP_IR) begin
      next_ir_shift = `IR_CAPTURE_VAL;
    end else if (state == TAP_SHIFT_IR) begin
      next_ir_shift = {tdi_in, ir_shift[`IR_LEN-1:1]};  // see [R15]
    end
    if (state == TAP_UPD_IR) begin
      next_ir   = ir_shift;
      next_mode = mode_of(ir_shift);
      if (ir_shift == `OP_PULSE_CFG) begin
        next_pulse_tgl = ~pulse_tgl;  // see [R09]
      end
      if (ir_shift == `OP_CONFIG_IO) begin
        next_cfgio_tgl = ~cfgio_tgl;  // see [R10] see [R11] see [R12]
      end
    end
    if (cap_dr) begin
      next_bypass   = 1'b0;  // see [R04]
      next_dr_shift = (sel == SEL_USER) ? USER_CODE : ID_VALUE;  // see [R05] see [R06]
    end else if (sh_dr) begin
      next_bypass   = tdi_in;
      next_dr_shift = {tdi_in, dr_shift[`ID_LEN-1:1]};
    end
  end

  // tdo moves on the falling edge so the host samples it on the next rising one
  always_comb begin
    next_tdo      = bypass_q;
    next_tdo_oe_n = 1'b1;
    if (state == TAP_SHIFT_IR) begin
      next_tdo      = ir_shift[0];
      next_tdo_oe_n = 1'b0;
    end else if (sh_dr) begin
      next_tdo_oe_n = 1'b0;
      unique case (sel)
        SEL_ID, SEL_USER: next_tdo = dr_shift[0];
        SEL_BOUNDARY:     next_tdo = bsr_so;
        SEL_IOSTD:        next_tdo = std_so;
        SEL_BYPASS:       next_tdo = bypass_q;  // see [R04] see [R07] see [R08]
      endcase
    end
  end

  always_ff @(posedge tck_in) begin
    trst_s1 <= rst_in;
    trst_s2 <= trst_s1;
    in_s1   <= {core_oe_n_in, core_out_in, pad_in};
    in_s2   <= in_s1;
    if (trst_s2) begin
      state     <= TAP_RESET;
      ir_shift  <= '0;
      ir        <= `IR_RESET_VAL;
      dr_shift  <= '0;
      bypass_q  <= 1'b0;
      pulse_tgl <= 1'b0;
      cfgio_tgl <= 1'b0;
      mode      <= PM_NORMAL;
    end else begin
      state     <= next_state;
      ir_shift  <= next_ir_shift;
      ir        <= next_ir;
      dr_shift  <= next_dr_shift;
      bypass_q  <= next_bypass;
      pulse_tgl <= next_pulse_tgl;
      cfgio_tgl <= next_cfgio_tgl;
      mode      <= next_mode;
    end
  end

  always_ff @(negedge tck_in) begin
    if (trst_s2) begin
      tdo_q      <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else begin
      tdo_q      <= next_tdo;
      tdo_oe_n_q <= next_tdo_oe_n;
    end
  end

  assign tdo_out      = tdo_q;
  assign tdo_oe_n_out = tdo_oe_n_q;

  // ---------------- master clock domain ----------------
  // levels are quasi-static (they move only at an update state or in test-logic-reset), so two flops suffice
  logic [LVL_W-1:0]   lvl_s1;
  logic [LVL_W-1:0]   lvl_s2;
  logic [1:0]         tgl_s1;
  logic [1:0]         tgl_s2;
  logic [1:0]         tgl_s3;
  logic               st_s1;
  logic               st_s2;
  logic               cfg_hold;
  logic               next_cfg_hold;
  logic               reconfig_q;
  logic [N_PINS-1:0]  next_pad;
  logic [N_PINS-1:0]  next_pad_oe_n;
  logic [N_PINS-1:0]  next_keep;
  logic [N_PINS-1:0]  pad_q;
  logic [N_PINS-1:0]  pad_oe_n_q;
  logic [N_PINS-1:0]  keep_q;
  logic               pulse_ev;
  logic               cfgio_ev;
  logic               test_drive;
  logic               test_hiz;
  logic [BSR_W-1:0]   bsr_m;
  pin_mode_t          mode_m;

  assign pulse_ev   = tgl_s2[0] ^ tgl_s3[0];
  assign cfgio_ev   = tgl_s2[1] ^ tgl_s3[1];
  assign mode_m     = pin_mode_t'(lvl_s2[1:0]);
  assign bsr_m      = lvl_s2[BSR_W+1:2];
  assign test_drive = (mode_m == PM_DRIVE) && !config_busy_in;  // see [R01]
  assign test_hiz   = (mode_m == PM_HIZ) && !config_busy_in;    // see [R01]

  always_comb begin
    // a new io-standard load wins over a reconfiguration in the same cycle
    next_cfg_hold = cfgio_ev ? 1'b1 : (pulse_ev ? 1'b0 : cfg_hold);  // see [R12]
    for (int i = 0; i < N_PINS; i++) begin
      next_pad[i]      = core_out_in[i];
      next_pad_oe_n[i] = !(power_good_in && configured_in) || core_oe_n_in[i];  // see [R14]
      if (test_drive) begin
        next_pad[i]      = bsr_m[i*`CELLS_PER_PIN + `CELL_DATA];      // see [R03] see [R08]
        next_pad_oe_n[i] = !bsr_m[i*`CELLS_PER_PIN + `CELL_ENABLE];
      end else if (test_hiz) begin
        next_pad_oe_n[i] = 1'b1;  // see [R07]
      end
      if (!power_good_in) begin
        next_pad_oe_n[i] = 1'b1;  // see [R14]
      end
      next_keep[i] = keep_en_in[i] && next_pad_oe_n[i] && (test_drive || test_hiz);  // see [R16]
    end
  end

  always_ff @(posedge mclk_in) begin
    lvl_s1 <= {std_upd[STD_W-1:0], bsr_upd, mode};
    lvl_s2 <= lvl_s1;
    tgl_s1 <= {cfgio_tgl, pulse_tgl};
    tgl_s2 <= tgl_s1;
    st_s1  <= config_status_n_in;
    st_s2  <= st_s1;
    if (rst_in) begin
      tgl_s3     <= 2'h0;
      cfg_hold   <= 1'b0;
      reconfig_q <= 1'b0;
      pad_q      <= '0;
      pad_oe_n_q <= '1;
      keep_q     <= '0;
    end else begin
      tgl_s3     <= tgl_s2;
      cfg_hold   <= next_cfg_hold;
      reconfig_q <= pulse_ev;  // see [R09]
      pad_q      <= next_pad;
      pad_oe_n_q <= next_pad_oe_n;
      keep_q     <= next_keep;
    end
  end

  assign reconfig_req_out         = reconfig_q;
  assign config_halt_out          = cfg_hold;  // see [R11]
  assign config_status_n_out      = 1'b0;
  assign config_status_n_oe_n_out = !cfg_hold;  // see [R12]
  assign status_low_out           = !st_s2;
  assign pad_out                  = pad_q;
  assign pad_oe_n_out             = pad_oe_n_q;
  assign pad_keep_out             = keep_q;
  assign io_std_out               = lvl_s2[LVL_W-1:BSR_W+2];  // see [R13]

  // ---------------- checks ----------------
  sequence tms_high_five;
    tms_in [*5];
  endsequence

  sequence load_pulse_code;
    (state == TAP_UPD_IR) && (ir_shift == `OP_PULSE_CFG);
  endsequence

  AST_TAP_RESET_BY_TMS: assert property (@(posedge tck_in) disable iff (trst_s2)  // see [R18]
    tms_high_five |=> state == TAP_RESET)
    else $error("tap did not reach reset after five tms highs");

  AST_IR_CAPTURE: assert property (@(posedge tck_in) disable iff (trst_s2)  // see [R15]
    state == TAP_CAP_IR |=> ir_shift == 10'h001)
    else $error("instruction capture value wrong");

  AST_BYPASS_ZERO: assert property (@(posedge tck_in) disable iff (trst_s2)  // see [R04]
    cap_dr && ir == 10'h3FF |=> !bypass_q)
    else $error("bypass cell not cleared at capture");

  AST_ID_CAPTURE: assert property (@(posedge tck_in) disable iff (trst_s2)  // see [R17]
    cap_dr && ir == 10'h006 |=> dr_shift == ID_VALUE && dr_shift[0])
    else $error("identification value not captured");

  AST_USER_CAPTURE: assert property (@(posedge tck_in) disable iff (trst_s2)  // see [R05]
    cap_dr && ir == 10'h007 |=> dr_shift == USER_CODE)
    else $error("user code not captured");

  AST_PULSE_TOGGLE: assert property (@(posedge tck_in) disable iff (trst_s2)  // see [R09]
    load_pulse_code |=> pulse_tgl != $past(pulse_tgl) ##1 pulse_tgl == $past(pulse_tgl))
    else $error("reconfiguration event not raised once");

  AST_UNKNOWN_BYPASS: assert property (@(posedge tck_in) disable iff (trst_s2)  // see [R19]
    state == TAP_UPD_IR && ir_shift == 10'h2C5 |=> sel == SEL_BYPASS && mode == PM_NORMAL)
    else $error("unassigned code did not pick bypass");

  AST_CFGIO_STATUS: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [R12]
    cfgio_ev |=> !config_status_n_oe_n_out && config_halt_out)
    else $error("status not pulled low after io-standard code");

  AST_POWER_FLOAT: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [R14]
    !power_good_in |=> pad_oe_n_out == '1)
    else $error("pin driven before power good");

  AST_HIZ_FLOAT: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [R07]
    test_hiz |=> pad_oe_n_out == '1)
    else $error("pin driven under high-impedance mode");

  AST_DRIVE_DATA: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [R03]
    test_drive && power_good_in |=> pad_out[0] == $past(bsr_m[`CELL_DATA]))
    else $error("pin not driven from boundary cell");
endmodule

// *** logic/bscan_regs.svh ***
// instruction codes, register lengths and cell layout of the boundary-scan port
`ifndef BSCAN_REGS_SVH
`define BSCAN_REGS_SVH

`define IR_LEN          10
`define ID_LEN          32
`define IR_CAPTURE_VAL  10'h001
`define IR_RESET_VAL    10'h006

`define OP_EXTEST       10'h000
`define OP_PULSE_CFG    10'h001
`define OP_SAMPLE       10'h005
`define OP_IDCODE       10'h006
`define OP_USERCODE     10'h007
`define OP_CLAMP        10'h00A
`define OP_HIGHZ        10'h00B
`define OP_CONFIG_IO    10'h00D
`define OP_BYPASS       10'h3FF

`define CELLS_PER_PIN   3
`define CELL_INPUT      0
`define CELL_DATA       1
`define CELL_ENABLE     2

`endif

// *** logic/bscan_pkg.sv ***
// types shared by the boundary-scan port modules
package bscan_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef enum logic [2:0] {SEL_BYPASS, SEL_ID, SEL_USER, SEL_BOUNDARY, SEL_IOSTD} dr_sel_t;

  typedef enum logic [1:0] {PM_NORMAL, PM_DRIVE, PM_HIZ} pin_mode_t;

endpackage

// *** logic/bscan_chain.sv ***
// capture / shift / update data register used for the boundary and io-standard chains
`timescale 1ns/1ps
module bscan_chain #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // tap strobes
  input  wire logic         capture_in,
  input  wire logic         shift_in,
  input  wire logic         update_in,
  input  wire logic         serial_in,
  input  wire logic [W-1:0] capture_data_in,
  // outputs
  output logic              serial_out,
  output logic [W-1:0]      update_data_out
);
  logic [W-1:0] shift_q;
  logic [W-1:0] next_shift;
  logic [W-1:0] hold_q;
  logic [W-1:0] next_hold;

  if (W < 2) begin : g_bad_width
    $error("bscan_chain needs at least two cells");
  end

  always_comb begin
    next_shift = shift_q;
    next_hold  = hold_q;
    if (capture_in) begin
      next_shift = capture_data_in;
    end else if (shift_in) begin
      next_shift = {serial_in, shift_q[W-1:1]};
    end
    // parallel outputs only move at update, so shifting never disturbs the pins
    if (update_in) begin
      next_hold = shift_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift_q <= '0;
      hold_q  <= '0;
    end else begin
      shift_q <= next_shift;
      hold_q  <= next_hold;
    end
  end

  assign serial_out      = shift_q[0];
  assign update_data_out = hold_q;
endmodule

// *** bench/jtag_host_model.sv ***
// test host model that clocks and scans the test access port
`timescale 1ns/1ps
module jtag_host_model (
  // test access port
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  input  wire logic tdo_in
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end

  // tck stands low between frames; tdo is taken at the rise
  task automatic clk(input logic tms, input logic tdi, output logic tdo);
    tms_out <= tms;
    tdi_out <= tdi;
    #40;
    tdo = tdo_in;
    tck_out <= 1'b1;
    #40;
    tck_out <= 1'b0;
  endtask

  task automatic reset_tap();
    logic d;
    repeat (6) clk(1'b1, tdi_out, d);
    clk(1'b0, tdi_out, d);
  endtask

  // idle -> capture -> n shifts lsb first -> update -> idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic d;
    dout = '0;
    clk(1'b1, tdi_out, d);
    if (ir) clk(1'b1, tdi_out, d);
    clk(1'b0, tdi_out, d);
    clk(1'b0, tdi_out, d);
    for (int i = 0; i < n; i++) begin
      clk(i == n - 1, din[i], d);
      dout[i] = d;
    end
    // released data line must not keep its last value
    clk(1'b1, ~din[n-1], d);
    clk(1'b0, ~din[n-1], d);
  endtask
endmodule

// *** bench/jtag_boundary_scan_control_tb_top.sv ***
// top-level bench for the boundary-scan port
`timescale 1ns/1ps
`include "bscan_regs.svh"
module jtag_boundary_scan_control_tb_top;
  localparam logic [15:0] PN = 16'h0C3A;      // arbitrary value
  localparam logic [10:0] MK = 11'h2B4;       // arbitrary value
  localparam logic [31:0] UC = 32'h5A5AC3C3;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        pg = 1'b1;
  logic        cfgd = 1'b1;
  logic        busy = 1'b0;
  logic        tck, tms, tdi, tdo, tdo_oe_n, st_n, st_o, st_oe_n, rcfg, halt, st_low;
  logic [7:0]  core = 8'hA5;
  logic [7:0]  core_oe_n = 8'hF0;
  logic [7:0]  keep = 8'h3C;
  logic [7:0]  board = 8'h96;
  logic [7:0]  pin, pout, poe_n, pkeep;
  logic [15:0] iostd;
  logic [63:0] r;
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          pulses = 0;

  always #25 mclk_in = ~mclk_in;
  // open-drain status wire with pull-up; pads see the board where undriven
  assign st_n = st_oe_n ? 1'b1 : st_o;
  assign pin  = (board & poe_n) | (pout & ~poe_n);

  bscan_ctrl #(.N_PINS(8), .IOSTD_W(2), .VERSION(4'h0), .PART_NUM(PN), .MAKER_ID(MK),
               .USER_CODE(UC)) u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .power_good_in(pg), .configured_in(cfgd),
    .config_busy_in(busy), .config_status_n_in(st_n), .config_status_n_out(st_o),
    .config_status_n_oe_n_out(st_oe_n), .reconfig_req_out(rcfg), .config_halt_out(halt),
    .status_low_out(st_low), .core_out_in(core), .core_oe_n_in(core_oe_n),
    .keep_en_in(keep), .pad_in(pin), .pad_out(pout), .pad_oe_n_out(poe_n),
    .pad_keep_out(pkeep), .io_std_out(iostd));

  jtag_host_model u_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));

  task automatic final_report();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang costs at most this many master cycles
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (rcfg === 1'b1) pulses <= pulses + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wm(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  // pins need a few master cycles after the update to settle
  task automatic ld(input logic [9:0] c);
    u_host.scan(1'b1, 10, {54'h0, c}, r);
    wm(6);
  endtask

  function automatic logic [23:0] bvec(input logic [7:0] d, input logic [7:0] e,
                                       input logic [7:0] x);
    logic [23:0] v;
    for (int i = 0; i < 8; i++) begin
      v[3*i+:3] = {e[i], d[i], x[i]};
    end
    return v;
  endfunction

  task automatic t_ids();
    u_host.scan(1'b0, 32, 64'h0, r);
    chk("reset idcode", {32'h0, 4'h0, PN, MK, 1'b1}, r);
    u_host.scan(1'b1, 10, {54'h0, `OP_USERCODE}, r);
    chk("ir capture", {54'h0, `IR_CAPTURE_VAL}, r);
    u_host.scan(1'b0, 32, 64'h0, r);
    chk("usercode", {32'h0, UC}, r);
    ld(`OP_IDCODE);
    u_host.scan(1'b0, 32, 64'h0, r);
    chk("idcode", {32'h0, 4'h0, PN, MK, 1'b1}, r);
    chk("tdo idle", 64'h1, {63'h0, tdo_oe_n});
  endtask

  task automatic t_bypass();
    logic [9:0] codes [4] = '{`OP_HIGHZ, `OP_CLAMP, `OP_BYPASS, 10'h2C5};
    foreach (codes[k]) begin
      ld(codes[k]);
      u_host.scan(1'b0, 9, 64'h0AD, r);
      chk("bypass path", {55'h0, 8'hAD, 1'b0}, r);
    end
    chk("unknown code drive", {56'h0, core_oe_n}, {56'h0, poe_n});
    chk("unknown code value", {56'h0, core}, {56'h0, pout});
  endtask

  task automatic t_scan_modes();
    logic [7:0] xp;
    xp = (board & core_oe_n) | (core & ~core_oe_n);
    ld(`OP_SAMPLE);
    u_host.scan(1'b0, 24, {40'h0, bvec(8'h5A, 8'hC3, 8'h00)}, r);
    chk("sample capture", {40'h0, bvec(8'h0, ~core_oe_n, xp)},
        r & {40'h0, bvec(8'h0, 8'hFF, 8'hFF)});
    chk("sample pins", {56'h0, core_oe_n}, {56'h0, poe_n});
    ld(`OP_EXTEST);
    chk("extest enable", 64'h3C, {56'h0, poe_n});
    chk("extest value", 64'h42, {56'h0, pout & 8'hC3});
    chk("extest keepers", {56'h0, keep & 8'h3C}, {56'h0, pkeep});
    u_host.scan(1'b0, 24, {40'h0, bvec(8'h5A, 8'hC3, 8'h00)}, r);
    xp = (board & 8'h3C) | 8'h42;
    chk("extest capture", {40'h0, bvec(8'h0, 8'h0, xp)},
        r & {40'h0, bvec(8'h0, 8'h0, 8'hFF)});
    ld(`OP_CLAMP);
    chk("clamp enable", 64'h3C, {56'h0, poe_n});
    chk("clamp value", 64'h42, {56'h0, pout & 8'hC3});
    ld(`OP_HIGHZ);
    chk("highz enable", 64'hFF, {56'h0, poe_n});
    chk("highz keepers", {56'h0, keep}, {56'h0, pkeep});
  endtask

  task automatic t_config();
    int p0;
    busy <= 1'b1;
    ld(`OP_EXTEST);
    chk("busy pins", {56'h0, core_oe_n}, {56'h0, poe_n});
    ld(`OP_CONFIG_IO);
    chk("halt", 64'h1, {63'h0, halt});
    chk("status pull", 64'h0, {63'h0, st_oe_n});
    chk("status seen", 64'h1, {63'h0, st_low});
    u_host.scan(1'b0, 16, 64'hB4E1, r);
    wm(6);
    chk("io std capture", 64'h0, r);
    chk("io std", 64'hB4E1, {48'h0, iostd});
    busy <= 1'b0;
    ld(`OP_IDCODE);
    chk("status held", 64'h0, {63'h0, st_oe_n});
    p0 = pulses;
    ld(`OP_PULSE_CFG);
    chk("reconfig pulses", 64'h1, 64'(pulses - p0));
    chk("status freed", 64'h1, {63'h0, st_oe_n});
    chk("halt freed", 64'h0, {63'h0, halt});
  endtask

  task automatic t_power();
    pg <= 1'b0;
    ld(`OP_BYPASS);
    chk("power down float", 64'hFF, {56'h0, poe_n});
    pg <= 1'b1;
    cfgd <= 1'b0;
    wm(6);
    chk("unconfigured float", 64'hFF, {56'h0, poe_n});
  endtask

  initial begin
    #13;
    fork
      u_host.reset_tap();
      begin
        wm(6);
        rst_in <= 1'b0;
      end
    join
    u_host.reset_tap();
    t_ids();
    t_bypass();
    t_scan_modes();
    t_config();
    t_power();
    final_report();
  end
endmodule
